// ===== verilog/dtc_xcvr_ctrl.sv
// top: differential transceiver control with register port and interrupts
//
// Contract
// RULE_01 - differential mode: never drive busy, select, reset
// RULE_02 - data enable when assert-data and target set
// RULE_03 - data enable on assert-data, phase match, initiator input (code enables only with I/O deasserted, data out)
// RULE_04 - target group enable: target and differential
// RULE_05 - initiator group enable: initiator and differential
// RULE_06 - arbitration id enable after arbitrate and bus free
// RULE_07 - busy output active exactly while asserting busy
// RULE_08 - select, reset outputs follow their control bits
// RULE_09 - target: interrupt on select-enable match with bus
// RULE_10 - output data register driven as id, any bits
// RULE_11 - initiator: optional interrupt on phase mismatch
// RULE_12 - differential enable is command bit 5
// RULE_13 - target role is mode bit 6
// RULE_14 - enables registered within one clock of inputs (code: pin-fed enables lag the pins by three clocks via the synchroniser)
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ns
module dtc_xcvr_ctrl #(
  parameter int BUS_FREE_CYCLES = dtc_pkg::BUS_FREE_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  input wire logic i_single_ended_select,
  input wire logic i_busy_receive_in_n,
  input wire logic i_select_receive_in_n,
  input wire logic i_reset_receive_in_n,
  input wire logic i_io_n,
  input wire logic i_cd_n,
  input wire logic i_msg_n,
  input wire logic i_req_n,
  input wire logic i_ack_n,
  input wire logic i_atn_n,
  input wire logic [7:0] i_data_n,
  output logic o_busy_pin_n,
  output logic o_busy_pin_oe,
  output logic o_select_pin_n,
  output logic o_select_pin_oe,
  output logic o_reset_pin_n,
  output logic o_reset_pin_oe,
  output logic [7:0] o_data_n,
  output logic [7:0] o_data_oe,
  output logic [3:0] o_tgt_ctl_n,
  output logic [3:0] o_tgt_ctl_oe,
  output logic [1:0] o_init_ctl_n,
  output logic [1:0] o_init_ctl_oe,
  output logic o_data_bus_xcvr_enable_n,
  output logic o_target_group_enable,
  output logic o_initiator_group_enable,
  output logic o_arbitration_id_enable,
  output logic o_busy_drive_out_n,
  output logic o_select_drive_out_n,
  output logic o_reset_drive_out_n
);

  // ==========================================================
  // pin sampling
  dtc_pkg::dtc_bus_type raw_bus;
  dtc_pkg::dtc_bus_type bus;
  logic [dtc_pkg::BUS_W-1:0] bus_sync;

  // inversion ahead of the first flop keeps the synchroniser clean
  assign raw_bus = {i_single_ended_select,
                    ~{i_busy_receive_in_n, i_select_receive_in_n, i_reset_receive_in_n,
                      i_io_n, i_cd_n, i_msg_n, i_req_n, i_ack_n, i_atn_n, i_data_n}};

  dtc_sync #(
    .W(dtc_pkg::BUS_W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(raw_bus),
    .o_sync(bus_sync)
  );

  assign bus = dtc_pkg::dtc_bus_type'(bus_sync);

  // ==========================================================
  // registers
  logic [7:0] out_data;
  logic [7:0] init_cmd;
  logic [7:0] mode;
  logic [dtc_pkg::TCR_W-1:0] tgt_cmd;
  logic [7:0] sel_enable;
  logic [dtc_pkg::EV_W-1:0] irq_enable;
  logic [dtc_pkg::EV_W-1:0] irq_status;
  logic [dtc_pkg::EV_W-1:0] events;
  logic clear_wr;

  function automatic logic wr_hit(input logic [3:0] addr, input logic [3:0] offset);
    wr_hit = i_wr && (addr == offset);
  endfunction

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      out_data <= dtc_pkg::REG_RESET;
      init_cmd <= dtc_pkg::REG_RESET;
      mode <= dtc_pkg::REG_RESET;
      tgt_cmd <= dtc_pkg::REG_RESET[dtc_pkg::TCR_W-1:0];
      sel_enable <= dtc_pkg::REG_RESET;
      irq_enable <= dtc_pkg::REG_RESET[dtc_pkg::EV_W-1:0];
    end else begin
      if (wr_hit(i_addr, dtc_pkg::REG_OUT_DATA)) begin
        out_data <= i_wdata;
      end
      if (wr_hit(i_addr, dtc_pkg::REG_INIT_CMD)) begin
        init_cmd <= i_wdata; // RULE_12
      end
      if (wr_hit(i_addr, dtc_pkg::REG_MODE)) begin
        mode <= i_wdata; // RULE_13
      end
      if (wr_hit(i_addr, dtc_pkg::REG_TGT_CMD)) begin
        tgt_cmd <= i_wdata[dtc_pkg::TCR_W-1:0];
      end
      if (wr_hit(i_addr, dtc_pkg::REG_SEL_ENABLE)) begin
        sel_enable <= i_wdata;
      end
      if (wr_hit(i_addr, dtc_pkg::REG_IRQ_ENABLE)) begin
        irq_enable <= i_wdata[dtc_pkg::EV_W-1:0];
      end
    end
  end

  assign clear_wr = wr_hit(i_addr, dtc_pkg::REG_IRQ_CLEAR);

  // ==========================================================
  // decoded control
  logic target_role_bit;
  logic diff_enable;
  logic assert_data;
  logic phase_match;

  assign target_role_bit = mode[dtc_pkg::MODE_TARGET]; // RULE_13
  assign diff_enable = init_cmd[dtc_pkg::ICR_DIFF_EN]; // RULE_12
  assign assert_data = init_cmd[dtc_pkg::ICR_ASSERT_DATA];
  assign phase_match = (bus.io == tgt_cmd[dtc_pkg::TCR_IO])
                    && (bus.cd == tgt_cmd[dtc_pkg::TCR_CD])
                    && (bus.msg == tgt_cmd[dtc_pkg::TCR_MSG]);

  // ==========================================================
  // arbitration
  dtc_pkg::dtc_arb_state_type arb_state;
  logic [dtc_pkg::FREE_CNT_W-1:0] free_cnt;
  logic bus_free_seen;

  // bus free only after both busy and select stay released
  assign bus_free_seen = (free_cnt >= dtc_pkg::FREE_CNT_W'(BUS_FREE_CYCLES));

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      free_cnt <= '0;
    end else if (bus.bsy || bus.sel) begin
      free_cnt <= '0;
    end else if (!bus_free_seen) begin
      free_cnt <= free_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      arb_state <= dtc_pkg::ARB_IDLE;
    end else if (!mode[dtc_pkg::MODE_ARBITRATE]) begin
      arb_state <= dtc_pkg::ARB_IDLE;
    end else begin
      case (arb_state)
        dtc_pkg::ARB_IDLE: begin
          arb_state <= dtc_pkg::ARB_WAIT_FREE;
        end
        dtc_pkg::ARB_WAIT_FREE: begin
          if (bus_free_seen) begin
            arb_state <= dtc_pkg::ARB_ON_BUS; // RULE_06
          end
        end
        dtc_pkg::ARB_ON_BUS: begin
          arb_state <= dtc_pkg::ARB_ON_BUS;
        end
        default: begin
          arb_state <= dtc_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // transceiver enables and drivers
  logic next_data_bus_xcvr_enable;
  logic next_id_drive;

  always_comb begin
    next_data_bus_xcvr_enable = assert_data && target_role_bit; // RULE_02
    if (assert_data && phase_match && !target_role_bit && !bus.io) begin
      next_data_bus_xcvr_enable = 1'b1; // RULE_03
    end
  end

  // id stays on the bus once won, until software drops arbitrate
  assign next_id_drive = (arb_state == dtc_pkg::ARB_ON_BUS);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_data_bus_xcvr_enable_n <= 1'b1;
      o_target_group_enable <= 1'b0;
      o_initiator_group_enable <= 1'b0;
      o_arbitration_id_enable <= 1'b0;
      o_busy_drive_out_n <= 1'b1;
      o_select_drive_out_n <= 1'b1;
      o_reset_drive_out_n <= 1'b1;
    end else begin
      o_data_bus_xcvr_enable_n <= ~next_data_bus_xcvr_enable; // RULE_14
      o_target_group_enable <= target_role_bit && diff_enable; // RULE_04
      o_initiator_group_enable <= !target_role_bit && diff_enable; // RULE_05
      o_arbitration_id_enable <= next_id_drive; // RULE_06
      o_busy_drive_out_n <= ~init_cmd[dtc_pkg::ICR_BSY]; // RULE_07
      o_select_drive_out_n <= ~init_cmd[dtc_pkg::ICR_SEL]; // RULE_08
      o_reset_drive_out_n <= ~init_cmd[dtc_pkg::ICR_RST]; // RULE_08
    end
  end

  // open-drain pins: the low level is constant, only the enables move
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_busy_pin_oe <= 1'b0;
      o_select_pin_oe <= 1'b0;
      o_reset_pin_oe <= 1'b0;
      o_data_oe <= '0;
      o_tgt_ctl_oe <= '0;
      o_init_ctl_oe <= '0;
      o_busy_pin_n <= 1'b1;
      o_select_pin_n <= 1'b1;
      o_reset_pin_n <= 1'b1;
      o_data_n <= 8'hff;
      o_tgt_ctl_n <= 4'hf;
      o_init_ctl_n <= 2'h3;
    end else begin
      o_busy_pin_oe <= bus.single_ended_select && init_cmd[dtc_pkg::ICR_BSY]; // RULE_01
      o_select_pin_oe <= bus.single_ended_select && init_cmd[dtc_pkg::ICR_SEL]; // RULE_01
      o_reset_pin_oe <= bus.single_ended_select && init_cmd[dtc_pkg::ICR_RST]; // RULE_01
      o_data_oe <= (next_data_bus_xcvr_enable || next_id_drive) ? out_data : '0; // RULE_10
      o_tgt_ctl_oe <= target_role_bit ? tgt_cmd : '0;
      o_init_ctl_oe <= target_role_bit ? 2'h0
                     : {init_cmd[dtc_pkg::ICR_ACK], init_cmd[dtc_pkg::ICR_ATN]};
      o_busy_pin_n <= 1'b0;
      o_select_pin_n <= 1'b0;
      o_reset_pin_n <= 1'b0;
      o_data_n <= 8'h00;
      o_tgt_ctl_n <= 4'h0;
      o_init_ctl_n <= 2'h0;
    end
  end

  // ==========================================================
  // events and interrupt
  logic sel_match;
  logic sel_match_d;
  logic mismatch;
  logic mismatch_d;
  logic rst_d;

  // no limit on the number of matching bits, any one is enough
  assign sel_match = target_role_bit && bus.sel && !bus.bsy
                  && |(bus.data & sel_enable); // RULE_09
  assign mismatch = !target_role_bit && bus.bsy && bus.req && !phase_match; // RULE_11

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sel_match_d <= 1'b0;
      mismatch_d <= 1'b0;
      rst_d <= 1'b0;
    end else begin
      sel_match_d <= sel_match;
      mismatch_d <= mismatch;
      rst_d <= bus.rst;
    end
  end

  always_comb begin
    events = '0;
    events[dtc_pkg::EV_SEL_MATCH] = sel_match && !sel_match_d; // RULE_09
    events[dtc_pkg::EV_PHASE_MISMATCH] = mismatch && !mismatch_d; // RULE_11
    events[dtc_pkg::EV_BUS_RESET] = bus.rst && !rst_d;
  end

  dtc_irq #(
    .W(dtc_pkg::EV_W)
  ) u_irq (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(events),
    .i_clear_wr(clear_wr),
    .i_clear_mask(i_wdata[dtc_pkg::EV_W-1:0]),
    .i_enable(irq_enable),
    .o_status(irq_status),
    .o_irq(o_irq)
  );

  // ==========================================================
  // read port, data in the cycle after the strobe
  logic [7:0] next_rdata;
  logic [7:0] icr_view;

  always_comb begin
    icr_view = init_cmd;
    icr_view[dtc_pkg::ICR_ARB_ACTIVE] = (arb_state != dtc_pkg::ARB_IDLE);
  end

  always_comb begin
    next_rdata = 8'h00;
    case (i_addr)
      dtc_pkg::REG_OUT_DATA: next_rdata = out_data;
      dtc_pkg::REG_INIT_CMD: next_rdata = icr_view;
      dtc_pkg::REG_MODE: next_rdata = mode;
      dtc_pkg::REG_TGT_CMD: next_rdata = {4'h0, tgt_cmd};
      dtc_pkg::REG_SEL_ENABLE: next_rdata = sel_enable;
      dtc_pkg::REG_BUS_STATUS: next_rdata = {phase_match, bus.req, bus.msg, bus.cd,
                                             bus.io, bus.sel, bus.bsy, bus.rst};
      dtc_pkg::REG_IRQ_STATUS: next_rdata = {5'h00, irq_status};
      dtc_pkg::REG_IRQ_ENABLE: next_rdata = {5'h00, irq_enable};
      dtc_pkg::REG_CUR_DATA: next_rdata = bus.data;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

endmodule

// ===== verilog/dtc_pkg.sv
// package: constants and types for the differential transceiver control block
package dtc_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int EV_W = 3;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] REG_OUT_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] REG_INIT_CMD = 4'h1;
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_TGT_CMD = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SEL_ENABLE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_BUS_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 4'h7;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CUR_DATA = 4'h9;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ==========================================================
  // field positions
  localparam int ICR_ASSERT_DATA = 0;
  localparam int ICR_ATN = 1;
  localparam int ICR_SEL = 2;
  localparam int ICR_BSY = 3;
  localparam int ICR_ACK = 4;
  localparam int ICR_DIFF_EN = 5;
  localparam int ICR_ARB_ACTIVE = 6;
  localparam int ICR_RST = 7;

  localparam int MODE_ARBITRATE = 0;
  localparam int MODE_TARGET = 6;

  localparam int TCR_IO = 0;
  localparam int TCR_CD = 1;
  localparam int TCR_MSG = 2;
  localparam int TCR_REQ = 3;
  localparam int TCR_W = 4;

  localparam int EV_SEL_MATCH = 0;
  localparam int EV_PHASE_MISMATCH = 1;
  localparam int EV_BUS_RESET = 2;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int BUS_FREE_NS = 400;
  localparam int BUS_FREE_CYCLES = (BUS_FREE_NS * CLK_MHZ + 999) / 1000;
  localparam int FREE_CNT_W = 12;

  // ==========================================================
  // types
  // bus sample, active high after inversion of the low-true pins
  typedef struct packed {
    logic single_ended_select;
    logic bsy;
    logic sel;
    logic rst;
    logic io;
    logic cd;
    logic msg;
    logic req;
    logic ack;
    logic atn;
    logic [DATA_W-1:0] data;
  } dtc_bus_type;

  localparam int BUS_W = $bits(dtc_bus_type);

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_WAIT_FREE = 2'b01,
    ARB_ON_BUS = 2'b10
  } dtc_arb_state_type;

endpackage

// ===== verilog/dtc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dtc_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  // ==========================================================
  // first stage is read only by the second
  logic [W-1:0] stage1;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// ===== verilog/dtc_irq.sv
// sticky interrupt status with clear and enable
`timescale 1ns/1ns
module dtc_irq #(
  parameter int W = 3
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_set,
  input wire logic i_clear_wr,
  input wire logic [W-1:0] i_clear_mask,
  input wire logic [W-1:0] i_enable,
  output logic [W-1:0] o_status,
  output logic o_irq
);

  // ==========================================================
  // set wins over a clear in the same cycle
  logic [W-1:0] next_status;

  always_comb begin
    next_status = o_status;
    if (i_clear_wr) begin
      next_status = next_status & ~i_clear_mask;
    end
    next_status = next_status | i_set;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_status <= '0;
      o_irq <= 1'b0;
    end else begin
      o_status <= next_status;
      o_irq <= |(next_status & i_enable);
    end
  end

endmodule

// ===== bench/dtc_xcvr_asserts.sv
// checker: port-level properties of the transceiver control block
`timescale 1ns/1ns
module dtc_xcvr_asserts (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_single_ended_select,
  input wire logic i_busy_receive_in_n,
  input wire logic i_select_receive_in_n,
  input wire logic o_irq,
  input wire logic o_busy_pin_oe,
  input wire logic o_select_pin_oe,
  input wire logic o_reset_pin_oe,
  input wire logic [7:0] o_data_oe,
  input wire logic o_data_bus_xcvr_enable_n,
  input wire logic o_target_group_enable,
  input wire logic o_initiator_group_enable,
  input wire logic o_arbitration_id_enable,
  input wire logic o_busy_drive_out_n,
  input wire logic o_select_drive_out_n,
  input wire logic o_reset_drive_out_n
);
  // ==========================================================
  // clocking and write sequences
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_icr_wr;
    i_wr && i_addr == dtc_pkg::REG_INIT_CMD;
  endsequence
  sequence s_mode_wr;
    i_wr && i_addr == dtc_pkg::REG_MODE;
  endsequence
  // ==========================================================
  // properties
  // five cycles covers the two sync flops plus the output flop
  property p_diff_in;
    !i_single_ended_select [*5] |-> !(o_busy_pin_oe || o_select_pin_oe || o_reset_pin_oe);
  endproperty
  a_diff_in: assert property (p_diff_in) else $error("pin driven in diff mode");
  property p_excl;
    !(o_target_group_enable && o_initiator_group_enable);
  endproperty
  a_excl: assert property (p_excl) else $error("both group enables");
  property p_diff_off;
    s_icr_wr ##0 !i_wdata[5] |-> ##2 !o_target_group_enable && !o_initiator_group_enable;
  endproperty
  a_diff_off: assert property (p_diff_off) else $error("group on, diff off");
  property p_role;
    s_mode_wr |-> ##2 ($past(i_wdata[6], 2) ? !o_initiator_group_enable
      : !o_target_group_enable);
  endproperty
  a_role: assert property (p_role) else $error("wrong group for role");
  property p_busy;
    s_icr_wr |-> ##2 o_busy_drive_out_n == !$past(i_wdata[3], 2);
  endproperty
  a_busy: assert property (p_busy) else $error("busy out wrong");
  property p_selrst;
    s_icr_wr |-> ##2 o_select_drive_out_n == !$past(i_wdata[2], 2)
      && o_reset_drive_out_n == !$past(i_wdata[7], 2);
  endproperty
  a_selrst: assert property (p_selrst) else $error("select or reset out wrong");
  property p_pin_busy;
    o_busy_pin_oe |-> !o_busy_drive_out_n;
  endproperty
  a_pin_busy: assert property (p_pin_busy) else $error("busy pin without out");
  property p_data_oe;
    o_data_oe != 8'h00 |-> !o_data_bus_xcvr_enable_n || o_arbitration_id_enable;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data driven, no enable");
  property p_arb;
    $rose(o_arbitration_id_enable) |-> $past(i_busy_receive_in_n, 5)
      && $past(i_select_receive_in_n, 5);
  endproperty
  a_arb: assert property (p_arb) else $error("id enable on busy bus");
  property p_mask;
    i_wr && i_addr == dtc_pkg::REG_IRQ_ENABLE && i_wdata[2:0] == 3'h0 |-> ##2 !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
endmodule
bind dtc_xcvr_ctrl dtc_xcvr_asserts u_chk (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_single_ended_select, .i_busy_receive_in_n, .i_select_receive_in_n, .o_irq,
  .o_busy_pin_oe, .o_select_pin_oe, .o_reset_pin_oe, .o_data_oe, .o_data_bus_xcvr_enable_n,
  .o_target_group_enable, .o_initiator_group_enable, .o_arbitration_id_enable,
  .o_busy_drive_out_n, .o_select_drive_out_n, .o_reset_drive_out_n);

// ===== bench/dtc_bus_model.sv
// bus model: terminated lines seen through the transceivers
`timescale 1ns/1ns
module dtc_bus_model (
  input wire dtc_pkg::dtc_bus_type i_agent,
  input wire logic i_bsy_oe,
  input wire logic i_sel_oe,
  input wire logic i_rst_oe,
  input wire logic [7:0] i_data_oe,
  input wire logic [3:0] i_tgt_oe,
  input wire logic [1:0] i_init_oe,
  output logic o_se,
  output logic o_bsy_n,
  output logic o_sel_n,
  output logic o_rst_n,
  output logic o_io_n,
  output logic o_cd_n,
  output logic o_msg_n,
  output logic o_req_n,
  output logic o_ack_n,
  output logic o_atn_n,
  output logic [7:0] o_data_n
);
  // ==========================================================
  // wired lines
  // terminators pull released lines high; any driver pulls low
  assign o_se = i_agent.single_ended_select;
  assign o_bsy_n = !(i_agent.bsy || i_bsy_oe);
  assign o_sel_n = !(i_agent.sel || i_sel_oe);
  assign o_rst_n = !(i_agent.rst || i_rst_oe);
  assign o_io_n = !(i_agent.io || i_tgt_oe[0]);
  assign o_cd_n = !(i_agent.cd || i_tgt_oe[1]);
  assign o_msg_n = !(i_agent.msg || i_tgt_oe[2]);
  assign o_req_n = !(i_agent.req || i_tgt_oe[3]);
  assign o_ack_n = !(i_agent.ack || i_init_oe[1]);
  assign o_atn_n = !(i_agent.atn || i_init_oe[0]);
  assign o_data_n = ~(i_agent.data | i_data_oe);
endmodule

// ===== bench/dtc_xcvr_ctrl_test.sv
// testbench: directed scenarios for the transceiver control block
`timescale 1ns/1ns
module dtc_xcvr_ctrl_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  dtc_pkg::dtc_bus_type agent = '{single_ended_select: 1'b1, default: '0};
  logic i_single_ended_select, i_busy_receive_in_n, i_select_receive_in_n;
  logic i_reset_receive_in_n, i_io_n, i_cd_n, i_msg_n, i_req_n, i_ack_n, i_atn_n;
  logic [7:0] i_data_n, o_rdata, o_data_oe;
  logic o_irq, o_busy_pin_oe, o_select_pin_oe, o_reset_pin_oe, o_data_bus_xcvr_enable_n;
  logic o_target_group_enable, o_initiator_group_enable, o_arbitration_id_enable;
  logic o_busy_drive_out_n, o_select_drive_out_n, o_reset_drive_out_n;
  logic [3:0] o_tgt_ctl_oe;
  logic [1:0] o_init_ctl_oe;
  logic [7:0] rv;
  int err_total = 0;
  int n_checks = 0;
  always #2 i_mclk = ~i_mclk;
  // ==========================================================
  // design and bus
  // short free count keeps the arbitration wait brief
  dtc_xcvr_ctrl #(.BUS_FREE_CYCLES(4)) dut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_irq, .i_single_ended_select, .i_busy_receive_in_n,
    .i_select_receive_in_n, .i_reset_receive_in_n, .i_io_n, .i_cd_n, .i_msg_n, .i_req_n,
    .i_ack_n, .i_atn_n, .i_data_n, .o_busy_pin_n(), .o_busy_pin_oe, .o_select_pin_n(),
    .o_select_pin_oe, .o_reset_pin_n(), .o_reset_pin_oe, .o_data_n(), .o_data_oe,
    .o_tgt_ctl_n(), .o_tgt_ctl_oe, .o_init_ctl_n(), .o_init_ctl_oe,
    .o_data_bus_xcvr_enable_n, .o_target_group_enable, .o_initiator_group_enable,
    .o_arbitration_id_enable, .o_busy_drive_out_n, .o_select_drive_out_n,
    .o_reset_drive_out_n);
  dtc_bus_model u_bus (.i_agent(agent), .i_bsy_oe(o_busy_pin_oe), .i_sel_oe(o_select_pin_oe),
    .i_rst_oe(o_reset_pin_oe), .i_data_oe(o_data_oe), .i_tgt_oe(o_tgt_ctl_oe),
    .i_init_oe(o_init_ctl_oe), .o_se(i_single_ended_select), .o_bsy_n(i_busy_receive_in_n),
    .o_sel_n(i_select_receive_in_n), .o_rst_n(i_reset_receive_in_n), .o_io_n(i_io_n),
    .o_cd_n(i_cd_n), .o_msg_n(i_msg_n), .o_req_n(i_req_n), .o_ack_n(i_ack_n),
    .o_atn_n(i_atn_n), .o_data_n(i_data_n));
  // ==========================================================
  // shared tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    rv = o_rdata;
  endtask
  // pins need three edges, writes two: six is safe for both
  task automatic idle();
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    idle();
    chk({o_data_bus_xcvr_enable_n, o_target_group_enable, o_initiator_group_enable,
      o_arbitration_id_enable, o_busy_drive_out_n, o_select_drive_out_n,
      o_reset_drive_out_n, o_irq}, 8'h8e);
    rd(dtc_pkg::REG_MODE);
    chk(rv, dtc_pkg::REG_RESET);
    rd(4'hf);
    chk(rv, 8'h00);
  endtask
  task automatic t_groups();
    for (int i = 0; i < 4; i++) begin
      wr(dtc_pkg::REG_MODE, i[1] ? 8'h40 : 8'h00);
      wr(dtc_pkg::REG_INIT_CMD, i[0] ? 8'h32 : 8'h12);
      idle();
      chk({6'h00, o_target_group_enable, o_initiator_group_enable},
        {6'h00, i[1] & i[0], !i[1] & i[0]});
      chk({o_tgt_ctl_oe, 2'h0, o_init_ctl_oe}, {6'h00, i[1] ? 2'h0 : 2'h3});
    end
  endtask
  // cases 0-1 target, 2-4 initiator; odd cases break phase match
  task automatic t_data_bus_xcvr_enable();
    for (int i = 0; i < 5; i++) begin
      wr(dtc_pkg::REG_MODE, i < 2 ? 8'h40 : 8'h00);
      wr(dtc_pkg::REG_INIT_CMD, i == 4 ? 8'h00 : 8'h01);
      @(posedge i_mclk);
      agent.io <= i[0];
      idle();
      chk({7'h00, o_data_bus_xcvr_enable_n}, {7'h00, i > 2});
    end
    @(posedge i_mclk);
    agent.io <= 1'b0;
  endtask
  task automatic t_drive();
    int b;
    for (int s = 1; s >= 0; s--) begin
      @(posedge i_mclk);
      agent.single_ended_select <= s[0];
      for (int k = 0; k < 3; k++) begin
        b = k == 0 ? 3 : (k == 1 ? 2 : 7);
        wr(dtc_pkg::REG_INIT_CMD, 8'h01 << b);
        idle();
        chk({5'h00, o_busy_drive_out_n, o_select_drive_out_n, o_reset_drive_out_n},
          {5'h00, b != 3, b != 2, b != 7});
        chk({5'h00, o_busy_pin_oe, o_select_pin_oe, o_reset_pin_oe},
          s[0] ? {5'h00, b == 3, b == 2, b == 7} : 8'h00);
      end
    end
    wr(dtc_pkg::REG_INIT_CMD, 8'h00);
    // the reset pin driven in single-ended mode left the bus reset event set
    rd(dtc_pkg::REG_IRQ_STATUS);
    chk(rv, 8'h04);
    wr(dtc_pkg::REG_IRQ_CLEAR, 8'h07);
  endtask
  task automatic t_arb();
    int n;
    @(posedge i_mclk);
    agent.bsy <= 1'b1;
    wr(dtc_pkg::REG_OUT_DATA, 8'ha5);
    wr(dtc_pkg::REG_MODE, 8'h01);
    idle();
    chk({7'h00, o_arbitration_id_enable}, 8'h00);
    @(posedge i_mclk);
    agent.bsy <= 1'b0;
    n = 0;
    while (o_arbitration_id_enable !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
    if (n == 60) begin
      err_total++;
      print_verdict();
    end
    chk(o_data_oe, 8'ha5);
    wr(dtc_pkg::REG_MODE, 8'h00);
    idle();
    chk({7'h00, o_arbitration_id_enable}, 8'h00);
  endtask
  task automatic t_irq();
    wr(dtc_pkg::REG_MODE, 8'h40);
    wr(dtc_pkg::REG_SEL_ENABLE, 8'h0c);
    wr(dtc_pkg::REG_IRQ_ENABLE, 8'h01);
    @(posedge i_mclk);
    agent.sel <= 1'b1;
    agent.data <= 8'h10;
    idle();
    chk({7'h00, o_irq}, 8'h00);
    @(posedge i_mclk);
    agent.data <= 8'h04;
    idle();
    chk({7'h00, o_irq}, 8'h01);
    rd(dtc_pkg::REG_IRQ_STATUS);
    chk(rv, 8'h01);
    wr(dtc_pkg::REG_IRQ_ENABLE, 8'h00);
    idle();
    chk({7'h00, o_irq}, 8'h00);
    @(posedge i_mclk);
    agent <= '{single_ended_select: 1'b1, default: '0};
    wr(dtc_pkg::REG_IRQ_CLEAR, 8'h07);
    rd(dtc_pkg::REG_IRQ_STATUS);
    chk(rv, 8'h00);
    // initiator expecting data out while the bus shows data in
    wr(dtc_pkg::REG_MODE, 8'h00);
    wr(dtc_pkg::REG_TGT_CMD, 8'h00);
    wr(dtc_pkg::REG_IRQ_ENABLE, 8'h02);
    @(posedge i_mclk);
    agent.bsy <= 1'b1;
    agent.req <= 1'b1;
    agent.io <= 1'b1;
    idle();
    chk({7'h00, o_irq}, 8'h01);
    rd(dtc_pkg::REG_IRQ_STATUS);
    chk(rv, 8'h02);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_groups();
    t_data_bus_xcvr_enable();
    t_drive();
    t_arb();
    t_irq();
    print_verdict();
  end
endmodule
